// file: core/sensor_regs_pkg.sv
// Purpose: shared constants of the humidity/temperature register bank
// Assumes: 7-bit register addresses, 8-bit register data, 200 MHz clock
// Notes: rate periods are kept in ns and turned into cycle counts here
package sensor_regs_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   // register addresses
   localparam logic [6:0] ADDR_RATE_POWER = 7'h20;
   localparam logic [6:0] ADDR_COMMAND = 7'h21;
   localparam logic [6:0] ADDR_READY_PIN = 7'h22;
   localparam logic [6:0] ADDR_FLAGS = 7'h27;
   localparam logic [6:0] ADDR_HUM_LO = 7'h28;
   localparam logic [6:0] ADDR_HUM_HI = 7'h29;
   localparam logic [6:0] ADDR_TEMP_LO = 7'h2A;
   localparam logic [6:0] ADDR_TEMP_HI = 7'h2B;
   // rate_power_control fields
   localparam int BIT_ACTIVE = 7;
   localparam int BIT_BLOCK_UPDATE = 2;
   localparam int RATE_LSB = 0;
   // command_control fields
   localparam int BIT_RELOAD = 7;
   localparam int BIT_HEATER = 1;
   localparam int BIT_ONE_SHOT = 0;
   // ready_pin_control fields
   localparam int BIT_READY_POLARITY = 7;
   localparam int BIT_READY_DRIVE = 6;
   localparam int BIT_READY_ENABLE = 2;
   // sample_flags fields
   localparam int BIT_HUM_AVAIL = 1;
   localparam int BIT_TEMP_AVAIL = 0;
   // reset values
   localparam logic [7:0] RST_RATE_POWER = 8'h00;
   localparam logic [1:0] RST_RATE = 2'h0;
   localparam logic [15:0] RST_RESULT = 16'h0000;
   // output_rate encodings
   localparam logic [1:0] RATE_ONE_SHOT = 2'h0;
   localparam logic [1:0] RATE_1HZ = 2'h1;
   localparam logic [1:0] RATE_7HZ = 2'h2;
   // timing
   localparam longint CLK_PERIOD_PS = 5000;
   localparam longint RATE_1HZ_PERIOD_NS = 1000000000;
   localparam longint RATE_7HZ_PERIOD_NS = 142857142;
   localparam longint RATE_12HZ5_PERIOD_NS = 80000000;
   localparam int unsigned RATE_1HZ_CYCLES = int'(RATE_1HZ_PERIOD_NS * 1000 / CLK_PERIOD_PS);
   localparam int unsigned RATE_7HZ_CYCLES = int'(RATE_7HZ_PERIOD_NS * 1000 / CLK_PERIOD_PS);
   localparam int unsigned RATE_12HZ5_CYCLES = int'(RATE_12HZ5_PERIOD_NS * 1000 / CLK_PERIOD_PS);
   localparam int TRIM_WORDS = 16;
endpackage

// file: core/trim_loader.sv
// Purpose: copies factory trim words from nonvolatile storage into trim registers
// Assumes: storage data is valid in the cycle that the registered address stands
// Notes: start_in is a one-cycle pulse; starts during LD_READ are dropped, one in the last busy cycle is taken
`timescale 1ns/1ps
module trim_loader
   import sensor_regs_pkg::*;
#(
   parameter int WORDS = TRIM_WORDS
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // control
   input wire logic start_in,
   output logic busy_out,
   output logic done_out,
   // storage read side
   output logic [3:0] nvm_addr_out,
   input wire logic [7:0] nvm_data_in,
   // trim register write side
   output logic trim_wr_out,
   output logic [3:0] trim_addr_out,
   output logic [7:0] trim_data_out
);
   typedef enum logic [0:0] {LD_IDLE, LD_READ} load_state_e;
   load_state_e state_r;
   logic [3:0] idx_r;
   logic rd_en_r;
   logic rd_last_r;

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_r <= LD_IDLE;
         idx_r <= 4'h0;
         rd_en_r <= 1'b0;
         rd_last_r <= 1'b0;
         nvm_addr_out <= 4'h0;
      end else begin
         rd_en_r <= 1'b0;
         rd_last_r <= 1'b0;
         unique case (state_r)
            LD_IDLE: begin
               if (start_in) begin
                  state_r <= LD_READ;
                  idx_r <= 4'h0;
               end
            end
            LD_READ: begin
               nvm_addr_out <= idx_r;
               rd_en_r <= 1'b1;
               idx_r <= idx_r + 4'h1;
               if (idx_r == 4'(WORDS - 1)) begin
                  rd_last_r <= 1'b1;
                  state_r <= LD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         trim_wr_out <= 1'b0;
         trim_addr_out <= 4'h0;
         trim_data_out <= 8'h00;
         done_out <= 1'b0;
      end else begin
         trim_wr_out <= rd_en_r;
         done_out <= rd_last_r;
         if (rd_en_r) begin
            trim_addr_out <= nvm_addr_out;
            trim_data_out <= nvm_data_in;
         end
      end
   end

   assign busy_out = (state_r != LD_IDLE) || rd_en_r;
endmodule // trim_loader

// file: core/output_pair.sv
// Purpose: one 16-bit result pair with optional block update
// Assumes: rd_lo_in / rd_hi_in are one-cycle read pulses
// Notes: a sample arriving while the pair is locked is held and applied at unlock
`timescale 1ns/1ps
module output_pair (
   // clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // control
   input wire logic block_update_in,
   input wire logic sample_valid_in,
   input wire logic [15:0] sample_in,
   input wire logic rd_lo_in,
   input wire logic rd_hi_in,
   // result
   output logic [15:0] value_out
);
   logic lo_read_r;
   logic hi_read_r;
   logic [15:0] pend_r;
   logic pend_v_r;
   logic locked;

   // half of the pair has been read and the other half not yet
   assign locked = block_update_in && (lo_read_r ^ hi_read_r);

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         lo_read_r <= 1'b0;
         hi_read_r <= 1'b0;
      end else if (!block_update_in || ((lo_read_r | rd_lo_in) && (hi_read_r | rd_hi_in))) begin
         lo_read_r <= 1'b0;
         hi_read_r <= 1'b0;
      end else begin
         lo_read_r <= lo_read_r | rd_lo_in;
         hi_read_r <= hi_read_r | rd_hi_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         value_out <= 16'h0000;
         pend_r <= 16'h0000;
         pend_v_r <= 1'b0;
      end else if (locked) begin
         if (sample_valid_in) begin
            pend_r <= sample_in;
            pend_v_r <= 1'b1;
         end
      end else if (sample_valid_in) begin
         value_out <= sample_in;
         pend_v_r <= 1'b0;
      end else if (pend_v_r) begin
         value_out <= pend_r;
         pend_v_r <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   chk_pair_hold_value: assert property (locked |=> $stable(value_out))
      else $error("result pair changed while half read");
   cover_pair_lock: cover property (locked && sample_valid_in);
endmodule // output_pair

// file: core/sensor_ctrl_status_regs.sv
// Purpose: control, status and result registers of a humidity/temperature sensor
// Assumes: serial front end decodes transfers into one-cycle rd/wr strobes
// Notes: read data is registered and valid the cycle after the read strobe
// What this block does
// - writing reload 1 copies trim from storage
// - reload bit self-clears when copy finishes
// - trim copy runs automatically after power-up
// - one-shot write starts one humidity/temperature acquisition
// - completion updates results, sets flags, clears one-shot
// - heater bit follows software writes only
// - ready polarity bit selects active high/low
// - ready drive bit selects push-pull/open drain
// - ready enable bit gates the ready pin
// - ready pin active on either available flag
// - ready inactive only after both high bytes read
// - flags update on every conversion regardless block_update
// - humidity flag set on sample, cleared by 29h read
// - temperature flag set on sample, cleared by 2Bh read
// - humidity result two's complement at 28h/29h
// - temperature low byte readable at 2Ah
// - temperature result two's complement at 2Ah/2Bh
// - block_update holds pair until both bytes read
// - output_rate zero converts only on one-shot
`timescale 1ns/1ps
module sensor_ctrl_status_regs
   import sensor_regs_pkg::*;
#(
   parameter int unsigned RATE1_CYCLES = RATE_1HZ_CYCLES,
   parameter int unsigned RATE7_CYCLES = RATE_7HZ_CYCLES,
   parameter int unsigned RATE12_CYCLES = RATE_12HZ5_CYCLES
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // register access
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // measurement chain
   output logic conv_start_out,
   input wire logic conv_done_in,
   input wire logic [15:0] humidity_sample_in,
   input wire logic [15:0] temperature_sample_in,
   output logic heater_on_out,
   // trim storage and trim registers
   output logic [3:0] nvm_addr_out,
   input wire logic [7:0] nvm_data_in,
   output logic trim_wr_out,
   output logic [3:0] trim_addr_out,
   output logic [7:0] trim_data_out,
   // data-ready pin
   output logic sample_ready_output_out,
   output logic sample_ready_oe_out
);
   logic active_r;
   logic block_update_r;
   logic [1:0] output_rate_r;
   logic reload_r;
   logic heater_r;
   logic one_shot_r;
   logic ready_polarity_r;
   logic ready_drive_type_r;
   logic ready_output_enable_r;
   logic humidity_available_r;
   logic temperature_available_r;
   logic conv_busy_r;
   logic powerup_load_r;
   logic [31:0] rate_cnt_r;
   logic rate_tick_r;
   logic [15:0] humidity_result;
   logic [15:0] temperature_result;
   logic load_busy;
   logic load_done;
   logic load_start;
   logic conv_finish;
   logic wr_cmd;
   logic rd_hum_hi;
   logic rd_temp_hi;
   logic ready_active;
   logic [31:0] rate_period;

   assign wr_cmd = reg_wr_in && (reg_addr_in == ADDR_COMMAND);
   assign rd_hum_hi = reg_rd_in && (reg_addr_in == ADDR_HUM_HI);
   assign rd_temp_hi = reg_rd_in && (reg_addr_in == ADDR_TEMP_HI);
   assign conv_finish = conv_done_in && conv_busy_r;

   // rate_power_control: active, block_update, output_rate
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         active_r <= RST_RATE_POWER[BIT_ACTIVE];
         block_update_r <= RST_RATE_POWER[BIT_BLOCK_UPDATE];
         output_rate_r <= RST_RATE;
      end else if (reg_wr_in && reg_addr_in == ADDR_RATE_POWER) begin
         active_r <= reg_wdata_in[BIT_ACTIVE];
         block_update_r <= reg_wdata_in[BIT_BLOCK_UPDATE];
         output_rate_r <= reg_wdata_in[RATE_LSB +: 2];
      end
   end

   // ready_pin_control; only documented bits are stored
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         ready_polarity_r <= 1'b0;
         ready_drive_type_r <= 1'b0;
         ready_output_enable_r <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == ADDR_READY_PIN) begin
         ready_polarity_r <= reg_wdata_in[BIT_READY_POLARITY];
         ready_drive_type_r <= reg_wdata_in[BIT_READY_DRIVE];
         ready_output_enable_r <= reg_wdata_in[BIT_READY_ENABLE];
      end
   end

   // trim reload: power-up pass first, then on request
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         powerup_load_r <= 1'b1;
      end else begin
         powerup_load_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         reload_r <= 1'b0;
      end else if (wr_cmd && reg_wdata_in[BIT_RELOAD]) begin
         reload_r <= 1'b1;
      end else if (load_done && !powerup_load_r) begin
         reload_r <= 1'b0;
      end
   end

   // a request while the loader is busy, its last busy cycle included, is merged; one in the done cycle starts a fresh pass
   assign load_start = powerup_load_r || (wr_cmd && reg_wdata_in[BIT_RELOAD] && !load_busy);

   trim_loader #(
      .WORDS(TRIM_WORDS)
   ) u_trim_loader (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .start_in(load_start),
      .busy_out(load_busy),
      .done_out(load_done),
      .nvm_addr_out(nvm_addr_out),
      .nvm_data_in(nvm_data_in),
      .trim_wr_out(trim_wr_out),
      .trim_addr_out(trim_addr_out),
      .trim_data_out(trim_data_out)
   );

   // heater is purely software-owned
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         heater_r <= 1'b0;
         heater_on_out <= 1'b0;
      end else begin
         if (wr_cmd) begin
            heater_r <= reg_wdata_in[BIT_HEATER];
         end
         heater_on_out <= wr_cmd ? reg_wdata_in[BIT_HEATER] : heater_r;
      end
   end

   // periodic timebase; idle in one-shot mode or power-down
   always_comb begin
      unique case (output_rate_r)
         RATE_1HZ: rate_period = 32'(RATE1_CYCLES);
         RATE_7HZ: rate_period = 32'(RATE7_CYCLES);
         default: rate_period = 32'(RATE12_CYCLES);
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         rate_cnt_r <= 32'h0000_0000;
         rate_tick_r <= 1'b0;
      end else if (output_rate_r == RATE_ONE_SHOT || !active_r) begin
         rate_cnt_r <= 32'h0000_0000;
         rate_tick_r <= 1'b0;
      end else if (rate_cnt_r >= rate_period - 32'h0000_0001) begin
         rate_cnt_r <= 32'h0000_0000;
         rate_tick_r <= 1'b1;
      end else begin
         rate_cnt_r <= rate_cnt_r + 32'h0000_0001;
         rate_tick_r <= 1'b0;
      end
   end

   // one-shot and conversion sequencing; a tick while busy is skipped
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         one_shot_r <= 1'b0;
         conv_busy_r <= 1'b0;
         conv_start_out <= 1'b0;
      end else begin
         conv_start_out <= 1'b0;
         if (conv_finish) begin
            conv_busy_r <= 1'b0;
            one_shot_r <= 1'b0;
         end else if (!conv_busy_r && wr_cmd && reg_wdata_in[BIT_ONE_SHOT]) begin
            one_shot_r <= 1'b1;
            conv_busy_r <= 1'b1;
            conv_start_out <= 1'b1;
         end else if (!conv_busy_r && rate_tick_r) begin
            conv_busy_r <= 1'b1;
            conv_start_out <= 1'b1;
         end
      end
   end

   // available flags: a new sample wins over a same-cycle read
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         humidity_available_r <= 1'b0;
         temperature_available_r <= 1'b0;
      end else begin
         if (conv_finish) begin
            humidity_available_r <= 1'b1;
         end else if (rd_hum_hi) begin
            humidity_available_r <= 1'b0;
         end
         if (conv_finish) begin
            temperature_available_r <= 1'b1;
         end else if (rd_temp_hi) begin
            temperature_available_r <= 1'b0;
         end
      end
   end

   output_pair u_humidity_pair (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .block_update_in(block_update_r),
      .sample_valid_in(conv_finish),
      .sample_in(humidity_sample_in),
      .rd_lo_in(reg_rd_in && reg_addr_in == ADDR_HUM_LO),
      .rd_hi_in(rd_hum_hi),
      .value_out(humidity_result)
   );

   output_pair u_temperature_pair (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .block_update_in(block_update_r),
      .sample_valid_in(conv_finish),
      .sample_in(temperature_sample_in),
      .rd_lo_in(reg_rd_in && reg_addr_in == ADDR_TEMP_LO),
      .rd_hi_in(rd_temp_hi),
      .value_out(temperature_result)
   );

   // ready pin: open drain only ever pulls low, released level comes from the pull-up
   assign ready_active = ready_output_enable_r && (humidity_available_r || temperature_available_r);

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         sample_ready_output_out <= 1'b0;
         sample_ready_oe_out <= 1'b1;
      end else begin
         sample_ready_output_out <= ready_active ^ ready_polarity_r;
         if (ready_drive_type_r) begin
            sample_ready_oe_out <= !(ready_active ^ ready_polarity_r);
         end else begin
            sample_ready_oe_out <= 1'b1;
         end
      end
   end

   // register read port; unmapped addresses read zero
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            ADDR_RATE_POWER: reg_rdata_out <= {active_r, 4'h0, block_update_r, output_rate_r};
            ADDR_COMMAND: reg_rdata_out <= {reload_r, 5'h00, heater_r, one_shot_r};
            ADDR_READY_PIN: reg_rdata_out <= {ready_polarity_r, ready_drive_type_r, 3'h0,
                                              ready_output_enable_r, 2'h0};
            ADDR_FLAGS: reg_rdata_out <= {6'h00, humidity_available_r, temperature_available_r};
            ADDR_HUM_LO: reg_rdata_out <= humidity_result[7:0];
            ADDR_HUM_HI: reg_rdata_out <= humidity_result[15:8];
            ADDR_TEMP_LO: reg_rdata_out <= temperature_result[7:0];
            ADDR_TEMP_HI: reg_rdata_out <= temperature_result[15:8];
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);

   chk_reload_starts: assert property (wr_cmd && reg_wdata_in[BIT_RELOAD] && !load_busy && !reload_r |=> load_busy)
      else $error("reload request did not start trim copy");
   chk_reload_self_clear: assert property (reload_r && load_done && !powerup_load_r
                                           && !(wr_cmd && reg_wdata_in[BIT_RELOAD]) |=> !reload_r)
      else $error("reload bit not cleared after copy");
   chk_powerup_copy: assert property ($past(powerup_load_r) && !powerup_load_r |-> load_busy)
      else $error("no trim copy after reset release");
   chk_one_shot_start: assert property (!conv_busy_r && wr_cmd && reg_wdata_in[BIT_ONE_SHOT] |=> conv_start_out && one_shot_r)
      else $error("one-shot write did not start conversion");
   chk_finish_effects: assert property (conv_finish |=> humidity_available_r && temperature_available_r && !one_shot_r
                                        && !conv_busy_r)
      else $error("conversion end did not set flags and clear one-shot");
   chk_heater_sw_only: assert property (!wr_cmd |=> $stable(heater_r))
      else $error("heater bit changed without a write");
   chk_ready_push_pull: assert property (!ready_drive_type_r |=> sample_ready_oe_out
                                         && sample_ready_output_out == $past(ready_active ^ ready_polarity_r))
      else $error("push-pull ready pin level wrong");
   chk_ready_open_drain: assert property (ready_drive_type_r && !(ready_active ^ ready_polarity_r) |=> sample_ready_oe_out
                                          && !sample_ready_output_out)
      else $error("open-drain ready pin not pulling low");
   chk_ready_disabled: assert property (!ready_output_enable_r |=> sample_ready_output_out == $past(ready_polarity_r))
      else $error("disabled ready pin not inactive");
   chk_ready_or_flags: assert property (ready_output_enable_r && (humidity_available_r || temperature_available_r)
                                        |=> sample_ready_output_out == !$past(ready_polarity_r))
      else $error("ready pin not active with a flag set");
   chk_hum_flag_clear: assert property (rd_hum_hi && !conv_finish |=> !humidity_available_r)
      else $error("humidity flag survived high-byte read");
   chk_temp_flag_clear: assert property (rd_temp_hi && !conv_finish |=> !temperature_available_r)
      else $error("temperature flag survived high-byte read");
   chk_flags_on_finish: assert property (conv_finish && block_update_r |=> humidity_available_r)
      else $error("flags not updated under block update");
   chk_one_shot_mode: assert property (output_rate_r == RATE_ONE_SHOT |-> ##1 !rate_tick_r)
      else $error("periodic tick in one-shot mode");
   chk_reserved_zero: assert property (reg_rd_in && reg_addr_in == ADDR_FLAGS |=> reg_rdata_out[7:2] == 6'h00)
      else $error("reserved flag bits not zero");

   cover_one_shot_done: cover property (conv_start_out ##[1:50] conv_finish);
   cover_reload_done: cover property (reload_r ##[1:40] !reload_r);
   cover_ready_cycle: cover property (ready_active ##[1:50] !ready_active);
   cover_periodic: cover property (rate_tick_r ##1 conv_start_out);
endmodule // sensor_ctrl_status_regs

// file: verif/sensor_chain_model.sv
// Purpose: measurement chain and trim storage beside the register bank
// Assumes: one conversion at a time
// Notes: answer time alternates short and long; samples are garbage outside done
`timescale 1ns/1ps
module sensor_chain_model (
   // clock and reset
   input wire logic mclk_in,
   input wire logic srst_in,
   // conversion
   input wire logic conv_start_in,
   output logic conv_done_out,
   output logic [15:0] hum_out,
   output logic [15:0] temp_out,
   // storage
   input wire logic [3:0] nvm_addr_in,
   output logic [7:0] nvm_data_out
);
   logic [3:0] k_r;
   logic [3:0] wait_r;
   // storage answers within the cycle that the registered address stands
   assign nvm_data_out = {4'hA, nvm_addr_in};
   always_ff @(posedge mclk_in) begin
      conv_done_out <= (wait_r == 4'h1);
      if (srst_in) begin
         k_r <= 4'h0;
         wait_r <= 4'h0;
      end else if (conv_start_in) begin
         wait_r <= k_r[0] ? 4'hC : 4'h4;
      end else if (wait_r != 4'h0) begin
         wait_r <= wait_r - 4'h1;
         if (wait_r == 4'h1) k_r <= k_r + 4'h1;
      end
   end
   // inverted outside the done cycle so a late sample grab shows
   assign hum_out = conv_done_out ? {4'h4, k_r, 4'h0, k_r} : ~{4'h4, k_r, 4'h0, k_r};
   assign temp_out = conv_done_out ? {4'hF, k_r, 4'h1, k_r} : ~{4'hF, k_r, 4'h1, k_r};
endmodule // sensor_chain_model

// file: verif/sensor_ctrl_status_regs_tb.sv
// Purpose: self-checking bench for the register bank
// Assumes: one-cycle strobes, read data the cycle after
// Notes: rate counts shortened; one periodic conversion runs at the end
`timescale 1ns/1ps
module sensor_ctrl_status_regs_tb;
   import sensor_regs_pkg::*;
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [6:0] reg_addr_in = 7'h00;
   logic reg_wr_in = 1'b0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out, nvm_data_in, trim_data_out;
   logic conv_start_out, conv_done_in, heater_on_out, trim_wr_out, pin_out, pin_oe;
   logic [15:0] hum, temp;
   logic [3:0] nvm_addr_out, trim_addr_out;
   int n_errors = 0;
   int n_checks = 0;
   int n_trim = 0;
   int n_start = 0;
   int cyc = 0;
   initial forever #2.5 mclk_in = ~mclk_in;
   sensor_ctrl_status_regs #(.RATE1_CYCLES(20), .RATE7_CYCLES(30), .RATE12_CYCLES(40)) DUT (
      .mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .conv_start_out(conv_start_out), .conv_done_in(conv_done_in), .humidity_sample_in(hum),
      .temperature_sample_in(temp), .heater_on_out(heater_on_out), .nvm_addr_out(nvm_addr_out),
      .nvm_data_in(nvm_data_in), .trim_wr_out(trim_wr_out), .trim_addr_out(trim_addr_out),
      .trim_data_out(trim_data_out), .sample_ready_output_out(pin_out), .sample_ready_oe_out(pin_oe));
   sensor_chain_model chain (.mclk_in(mclk_in), .srst_in(srst_in), .conv_start_in(conv_start_out),
      .conv_done_out(conv_done_in), .hum_out(hum), .temp_out(temp), .nvm_addr_in(nvm_addr_out),
      .nvm_data_out(nvm_data_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic pin(input logic [1:0] e);
      idle(3);
      chk({6'h00, pin_oe, pin_out}, {6'h00, e});
   endtask
   task automatic close_out;
      if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // sampled away from the rising edge so registered outputs have settled
   always @(negedge mclk_in) begin
      cyc++;
      if (trim_wr_out === 1'b1) begin
         n_trim++;
         chk(trim_data_out, {4'hA, trim_addr_out});
      end
      if (conv_start_out === 1'b1) n_start++;
      if (cyc == 5000) begin
         n_errors++;
         close_out;
      end
   end
   initial begin
      repeat (5) @(posedge mclk_in);
      srst_in <= 1'b0;
      idle(30);
      chk(8'(n_trim), 8'h10);
      pin(2'b10);
      rd(ADDR_COMMAND, 8'h00);
      rd(ADDR_FLAGS, 8'h00);
      rd(7'h23, 8'h00);
      wr(ADDR_READY_PIN, 8'hFF);
      rd(ADDR_READY_PIN, 8'hC4);
      idle(3);
      chk({7'h00, pin_oe}, 8'h00);
      wr(ADDR_READY_PIN, 8'h04);
      wr(ADDR_COMMAND, 8'h01);
      rd(ADDR_COMMAND, 8'h01);
      idle(20);
      rd(ADDR_COMMAND, 8'h00);
      rd(ADDR_FLAGS, 8'h03);
      pin(2'b11);
      rd(ADDR_HUM_LO, 8'h01);
      rd(ADDR_HUM_HI, 8'h41);
      rd(ADDR_FLAGS, 8'h01);
      pin(2'b11);
      rd(ADDR_TEMP_LO, 8'h11);
      rd(ADDR_TEMP_HI, 8'hF1);
      rd(ADDR_FLAGS, 8'h00);
      pin(2'b10);
      wr(ADDR_COMMAND, 8'h02);
      idle(2);
      chk({7'h00, heater_on_out}, 8'h01);
      idle(40);
      rd(ADDR_COMMAND, 8'h02);
      wr(ADDR_COMMAND, 8'h00);
      idle(2);
      chk({7'h00, heater_on_out}, 8'h00);
      n_trim = 0;
      wr(ADDR_COMMAND, 8'h80);
      rd(ADDR_COMMAND, 8'h80);
      idle(30);
      chk(8'(n_trim), 8'h10);
      rd(ADDR_COMMAND, 8'h00);
      wr(ADDR_RATE_POWER, 8'h84);
      rd(ADDR_RATE_POWER, 8'h84);
      wr(ADDR_READY_PIN, 8'hC4);
      wr(ADDR_COMMAND, 8'h01);
      idle(30);
      pin(2'b10);
      rd(ADDR_HUM_LO, 8'h02);
      wr(ADDR_COMMAND, 8'h01);
      idle(30);
      rd(ADDR_FLAGS, 8'h03);
      rd(ADDR_HUM_HI, 8'h42);
      idle(2);
      rd(ADDR_HUM_LO, 8'h03);
      rd(ADDR_HUM_HI, 8'h43);
      rd(ADDR_TEMP_LO, 8'h13);
      rd(ADDR_TEMP_HI, 8'hF3);
      chk(8'(n_start), 8'h03);
      wr(ADDR_RATE_POWER, 8'h85);
      idle(25);
      wr(ADDR_RATE_POWER, 8'h84);
      idle(30);
      chk(8'(n_start), 8'h04);
      rd(ADDR_FLAGS, 8'h03);
      close_out;
   end
endmodule // sensor_ctrl_status_regs_tb
